// ---- design/i2c_enable_abort_irq_clear.v ----
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "i2c_ctrl_map.vh"
module i2c_enable_abort_irq_clear
(
   input wire i_clock,
   input wire i_rst,
   input wire [7:0] i_address,
   input wire i_read,
   input wire i_write,
   input wire [31:0] i_writedata,
   output wire [31:0] o_readdata,
   output wire o_waitrequest,
   input wire i_master_mode,
   input wire i_tx_not_empty,
   input wire i_rx_active,
   input wire i_byte_done,
   input wire i_bus_stop_seen,
   input wire i_bus_start_seen,
   input wire i_broadcast_address_hit,
   input wire [15:0] i_abandon_cause,
   input wire i_link_scl,
   output wire o_start_transfer,
   output wire o_issue_stop,
   output wire o_tx_flush,
   output wire o_rx_flush,
   output wire o_withhold_ack,
   output wire o_busy,
   output wire o_irq
);
   // link-side event pulses arrive from the serial engine clocked here
   localparam ST_IDLE = 2'b00;
   localparam ST_XFER = 2'b01;
   localparam ST_STOP = 2'b10;
   localparam ST_DRAIN = 2'b11;
   localparam integer LINK_CYC = (`LINK_BIT_NS * (`CLOCK_HZ / 1000000) + 999) / 1000;
   reg [1:0] state_ff;
   reg [1:0] nxt_state;
   reg enable_ff;
   reg abort_ff;
   reg cmd_hold_ff;
   reg [31:0] flags_ff;
   reg [31:0] mask_ff;
   reg [15:0] cause_ff;
   reg tx_flushed_ff;
   reg [31:0] rdata_ff;
   reg ack_ff;
   reg scl_meta_ff;
   reg scl_sync_ff;
   reg scl_prev_ff;
   reg [3:0] tick_ff;
   reg abandon_evt;
   wire wr_en;
   wire rd_en;
   wire scl_fall;
   wire idle;
   wire [31:0] set_vec;
   wire [31:0] clr_vec;
   assign wr_en = i_write & ack_ff;
   assign rd_en = i_read & ack_ff;
   assign o_waitrequest = (i_read | i_write) & ~ack_ff;
   assign o_readdata = rdata_ff;
   assign idle = (state_ff == ST_IDLE);
   assign scl_fall = scl_prev_ff & ~scl_sync_ff;
   // link clock sampled through two flops before edge detection
   always @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         scl_meta_ff <= 1'b0;
         scl_sync_ff <= 1'b0;
         scl_prev_ff <= 1'b0;
         tick_ff <= 4'h0;
      end
      else
      begin
         scl_meta_ff <= i_link_scl;
         scl_sync_ff <= scl_meta_ff;
         scl_prev_ff <= scl_sync_ff;
         if (scl_fall)
            tick_ff <= LINK_CYC[3:0];
         else if (tick_ff != 4'h0)
            tick_ff <= tick_ff - 4'h1;
      end
   end
   always @*
   begin
      nxt_state = state_ff;
      abandon_evt = 1'b0;
      case (state_ff)
         ST_IDLE:
            if (enable_ff & i_master_mode & ~cmd_hold_ff & i_tx_not_empty & ~tx_flushed_ff
                & ~abort_ff)
               nxt_state = ST_XFER;
            else if (abort_ff)
               nxt_state = ST_STOP;
         ST_XFER:
            if (i_byte_done & (abort_ff | ~enable_ff))
               nxt_state = ST_STOP;
            else if (i_byte_done & ~i_tx_not_empty)
               nxt_state = ST_STOP;
         ST_STOP:
            if (scl_fall | (tick_ff == 4'h0))
               nxt_state = ST_DRAIN;
         ST_DRAIN:
         begin
            nxt_state = ST_IDLE;
            abandon_evt = abort_ff;
         end
         default:
            nxt_state = ST_IDLE;
      endcase
   end
   assign o_start_transfer = (state_ff == ST_IDLE) & (nxt_state == ST_XFER);
   assign o_issue_stop = (state_ff == ST_STOP);
   assign o_tx_flush = ~enable_ff | tx_flushed_ff;
   assign o_rx_flush = ~enable_ff;
   assign o_withhold_ack = ~enable_ff & i_rx_active;
   assign o_busy = ~idle;
   // flags keep being gated onto irq while controller drains after disable
   assign o_irq = |(flags_ff & mask_ff);
   assign set_vec = ({20'h0, i_broadcast_address_hit, i_bus_start_seen, i_bus_stop_seen,
                      2'b00, abandon_evt, 6'h00}) & `FLAG_MASK;
   assign clr_vec = {20'h0,
                     rd_en & (i_address == `OFS_BROADCAST_FLAG_CLEAR),
                     rd_en & (i_address == `OFS_START_FLAG_CLEAR),
                     rd_en & (i_address == `OFS_STOP_FLAG_CLEAR),
                     2'b00,
                     rd_en & (i_address == `OFS_ABANDON_FLAG_CLEAR),
                     6'h00};
   // software-side decode; writes and clears land on the edge that ends the answer cycle
   wire wr_enable_reg;
   wire wr_mask_reg;
   wire wr_unmasked_reg;
   wire abort_req;
   wire rd_cap;
   wire [31:0] nxt_flags;
   reg [31:0] nxt_rdata;
   localparam [31:0] FLAG_BITS = `FLAG_MASK;
   genvar b;

   assign wr_enable_reg = wr_en & (i_address == `OFS_CONTROLLER_ENABLE);
   assign wr_mask_reg = wr_en & (i_address == `OFS_IRQ_MASK);
   assign wr_unmasked_reg = wr_en & (i_address == `OFS_UNMASKED_IRQ_FLAGS);

   // read data is captured one edge early so it stands while waitrequest is low
   assign rd_cap = i_read & ~ack_ff;
   // an abort write counts only if the controller was enabled beforehand
   assign abort_req = wr_enable_reg & enable_ff & i_writedata[`BIT_ABORT];

   // readback words, reserved positions fixed at zero
   wire [31:0] enable_word;
   wire [31:0] masked_word;
   wire [31:0] activity_word;
   wire [31:0] cause_word;
   assign enable_word = {29'h0, cmd_hold_ff, abort_ff, enable_ff};
   assign masked_word = flags_ff & mask_ff;
   assign activity_word = {31'h0, ~idle};
   assign cause_word = {16'h0, cause_ff};

   // one flag cell per interrupt bit; unused positions are tied low
   generate
      for (b = 0; b < 32; b = b + 1)
      begin : g_flag
         if (FLAG_BITS[b])
         begin : g_used
            wire sw_clear;
            wire rd_clear;
            assign sw_clear = wr_unmasked_reg & i_writedata[b];
            assign rd_clear = clr_vec[b];
            // a hardware set in the clearing cycle wins, so no event is lost
            assign nxt_flags[b] = (flags_ff[b] & ~sw_clear & ~rd_clear) | set_vec[b];
         end
         else
         begin : g_unused
            assign nxt_flags[b] = 1'b0;
         end
      end
   endgenerate

   always @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         state_ff <= ST_IDLE;
         ack_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         // every access is answered in its second cycle
         ack_ff <= (i_read | i_write) & ~ack_ff;
      end
   end

   always @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         flags_ff <= `RESET_ZERO;
      end
      else
      begin
         flags_ff <= nxt_flags;
      end
   end

   always @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         mask_ff <= `RESET_ZERO;
      end
      else if (wr_mask_reg)
      begin
         mask_ff <= i_writedata & `FLAG_MASK;
      end
   end

   always @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         cause_ff <= 16'h0000;
         tx_flushed_ff <= 1'b0;
      end
      else if (abandon_evt)
      begin
         // tx stays flushed until software acknowledges the abandon
         cause_ff <= i_abandon_cause;
         tx_flushed_ff <= 1'b1;
      end
      else if (clr_vec[`BIT_ABANDON])
      begin
         cause_ff <= 16'h0000;
         tx_flushed_ff <= 1'b0;
      end
   end

   always @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         abort_ff <= 1'b0;
      end
      else if (abandon_evt)
      begin
         abort_ff <= 1'b0;
      end
      else if (abort_req)
      begin
         // software can only set it; a written zero is ignored
         abort_ff <= 1'b1;
      end
   end

   always @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         enable_ff <= 1'b0;
         cmd_hold_ff <= 1'b0;
      end
      else if (wr_enable_reg)
      begin
         // disabling mid-transfer is allowed; the state machine finishes the byte
         enable_ff <= i_writedata[`BIT_ENABLE];
         cmd_hold_ff <= i_writedata[`BIT_CMD_HOLD];
      end
   end

   always @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         rdata_ff <= `RESET_ZERO;
      end
      else if (rd_cap)
      begin
         rdata_ff <= nxt_rdata;
      end
      else
      begin
         // bus sees zero outside the answer cycle
         rdata_ff <= `RESET_ZERO;
      end
   end

   // clear registers return the flag as it stood before the clear
   always @*
   begin
      nxt_rdata = `RESET_ZERO;
      // unmapped offsets fall through to zero
      case (i_address)
         `OFS_CONTROLLER_ENABLE:
         begin
            nxt_rdata = enable_word;
         end

         `OFS_UNMASKED_IRQ_FLAGS:
         begin
            nxt_rdata = flags_ff;
         end

         `OFS_MASKED_IRQ_FLAGS:
         begin
            nxt_rdata = masked_word;
         end

         `OFS_IRQ_MASK:
         begin
            nxt_rdata = mask_ff;
         end

         `OFS_ABANDON_CAUSE:
         begin
            nxt_rdata = cause_word;
         end

         `OFS_ACTIVITY_STATUS:
         begin
            nxt_rdata = activity_word;
         end

         `OFS_STOP_FLAG_CLEAR:
         begin
            nxt_rdata = {31'h0, flags_ff[`BIT_STOP_SEEN]};
         end

         `OFS_START_FLAG_CLEAR:
         begin
            nxt_rdata = {31'h0, flags_ff[`BIT_START_SEEN]};
         end

         `OFS_BROADCAST_FLAG_CLEAR:
         begin
            nxt_rdata = {31'h0, flags_ff[`BIT_BROADCAST]};
         end

         `OFS_ABANDON_FLAG_CLEAR:
         begin
            nxt_rdata = {31'h0, flags_ff[`BIT_ABANDON]};
         end

         default:
         begin
            nxt_rdata = `RESET_ZERO;
         end
      endcase
   end
endmodule

// ---- include/i2c_ctrl_map.vh ----
`ifndef I2C_CTRL_MAP_VH
`define I2C_CTRL_MAP_VH
// register byte offsets
`define OFS_STOP_FLAG_CLEAR 8'h60
`define OFS_START_FLAG_CLEAR 8'h64
`define OFS_BROADCAST_FLAG_CLEAR 8'h68
`define OFS_CONTROLLER_ENABLE 8'h6C
`define OFS_ABANDON_FLAG_CLEAR 8'h54
`define OFS_UNMASKED_IRQ_FLAGS 8'h34
`define OFS_MASKED_IRQ_FLAGS 8'h2C
`define OFS_IRQ_MASK 8'h30
`define OFS_ABANDON_CAUSE 8'h80
`define OFS_ACTIVITY_STATUS 8'h70
// field positions
`define BIT_ENABLE 0
`define BIT_ABORT 1
`define BIT_CMD_HOLD 2
`define BIT_ABANDON 6
`define BIT_STOP_SEEN 9
`define BIT_START_SEEN 10
`define BIT_BROADCAST 11
`define FLAG_MASK 32'h00000E40
`define RESET_ZERO 32'h00000000
// timing
`define CLOCK_HZ 10000000
`define LINK_BIT_NS 800
`endif

// ---- sim/i2c_ctrl_props_properties.sv ----
`timescale 1ns/1ps
module i2c_ctrl_props
(
   input wire i_clock,
   input wire i_rst,
   input wire [7:0] i_address,
   input wire i_read,
   input wire i_write,
   input wire [31:0] i_writedata,
   input wire i_master_mode,
   input wire i_tx_not_empty,
   input wire [31:0] o_readdata,
   input wire o_waitrequest,
   input wire o_start_transfer,
   input wire o_issue_stop,
   input wire o_tx_flush,
   input wire o_rx_flush,
   input wire o_busy
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);
   reg en_q = 1'b0;
   reg abort_pend = 1'b0;
   // abort is only pending after an accepted write while enabled
   always @(posedge i_clock)
   begin
      if (i_rst)
      begin
         en_q <= 1'b0;
         abort_pend <= 1'b0;
      end
      else
      begin
         if ($fell(o_issue_stop))
            abort_pend <= 1'b0;
         if (i_write && !o_waitrequest && i_address == 8'h6C)
         begin
            en_q <= i_writedata[0];
            if (en_q && i_writedata[1])
               abort_pend <= 1'b1;
         end
      end
   end
   wire ans = i_read && !o_waitrequest;
   wire clr = i_address == 8'h60 || i_address == 8'h64 || i_address == 8'h68;
   chk_read_answer: assert property (i_read && o_waitrequest |=> !o_waitrequest)
      else $error("read unanswered");
   chk_rdata_quiet: assert property (o_readdata != 32'h0 |-> ans)
      else $error("stray readdata");
   chk_clear_reserved: assert property (ans && clr |-> o_readdata[31:1] == 31'h0)
      else $error("clear reg reserved bits");
   chk_enable_reserved: assert property (ans && i_address == 8'h6C |-> !o_readdata[31:3])
      else $error("enable reserved bits");
   chk_start_cause: assert property (o_start_transfer |-> i_master_mode && i_tx_not_empty)
      else $error("start without cause");
   chk_stop_bound: assert property ($rose(o_issue_stop) |-> ##[1:12] !o_issue_stop)
      else $error("stop too long");
   chk_stop_flush: assert property ($fell(o_issue_stop) && abort_pend |-> ##[0:3] o_tx_flush)
      else $error("no flush after stop");
   chk_flush_pair: assert property (o_rx_flush |-> o_tx_flush)
      else $error("fifos not flushed together");
   chk_stop_busy: assert property (o_issue_stop |-> o_busy)
      else $error("stop while idle");
endmodule
bind i2c_enable_abort_irq_clear i2c_ctrl_props chk_u (.*);

// ---- sim/i2c_far_side.sv ----
`timescale 1ns/1ps
module i2c_far_side
(
   input wire i_busy,
   output reg o_scl
);
   // clock only inside a frame; pulled-up line idles high
   initial
   begin
      o_scl = 1'b1;
      #37;
      forever #400 o_scl = i_busy ? ~o_scl : 1'b1;
   end
endmodule

// ---- sim/i2c_enable_abort_irq_clear_bench.sv ----
`timescale 1ns/1ps
module i2c_enable_abort_irq_clear_bench;
   reg i_clock = 0, i_rst = 1, i_read = 0, i_write = 0, i_byte_done = 0;
   reg i_master_mode = 0, i_tx_not_empty = 0, i_rx_active = 0;
   reg [7:0] i_address = 0, a;
   reg [31:0] i_writedata = 0, expq[$];
   reg [15:0] i_abandon_cause = 0;
   reg [2:0] ev = 0;
   wire [31:0] o_readdata;
   wire o_waitrequest, o_start_transfer, o_issue_stop, o_tx_flush, o_rx_flush;
   wire o_withhold_ack, o_busy, o_irq, i_link_scl;
   wire i_bus_stop_seen = ev[0], i_bus_start_seen = ev[1], i_broadcast_address_hit = ev[2];
   integer n_mismatch = 0, checked = 0, n_start = 0, seed = 32'h4141, i;
   i2c_enable_abort_irq_clear dut_u (.*);
   i2c_far_side far_u (.i_busy(o_busy), .o_scl(i_link_scl));
   always #50 i_clock = ~i_clock;
   task chk(input [31:0] s, input [31:0] e);
      begin
         checked = checked + 1;
         if (s !== e)
         begin
            n_mismatch = n_mismatch + 1;
            $display("[ERR] %0t got %h want %h", $time, s, e);
         end
      end
   endtask
   task print_verdict;
      begin
         if (n_mismatch == 0 && checked > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask
   task acc(input w, input [7:0] ad, input [31:0] d);
      reg wt;
      begin
         @(posedge i_clock);
         if (!w)
            expq.push_back(d);
         i_read <= !w;
         i_write <= w;
         i_address <= ad;
         i_writedata <= d;
         wt = 1;
         for (i = 0; wt && i < 20; i = i + 1)
         begin
            @(negedge i_clock);
            wt = o_waitrequest;
            @(posedge i_clock);
         end
         i_read <= 0;
         i_write <= 0;
         if (wt)
         begin
            n_mismatch = n_mismatch + 1;
            print_verdict;
         end
      end
   endtask
   always @(negedge i_clock)
   begin
      if (o_start_transfer === 1'b1)
         n_start = n_start + 1;
      if (i_read === 1'b1 && o_waitrequest === 1'b0)
         chk(o_readdata, expq.pop_front());
   end
   initial
   begin
      repeat (20) @(posedge i_clock);
      i_rst <= 0;
      acc(0, 8'h6C, 32'h0);
      acc(1, 8'hF0, $random(seed));
      acc(0, 8'hF0, 32'h0);
      for (a = 8'h60; a < 8'h6C; a = a + 8'h4)
      begin
         @(posedge i_clock);
         ev <= 3'h1 << a[3:2];
         @(posedge i_clock);
         ev <= 3'h0;
         acc(1, a, 32'hFFFFFFFF);
         acc(0, a, 32'h1);
         acc(0, a, 32'h0);
      end
      acc(1, 8'h6C, 32'h2);
      acc(0, 8'h6C, 32'h0);
      i_master_mode <= 1;
      i_tx_not_empty <= 1;
      acc(1, 8'h6C, 32'h5);
      repeat (10) @(posedge i_clock);
      chk(n_start, 0);
      acc(1, 8'h6C, 32'h1);
      repeat (10) @(posedge i_clock);
      chk(n_start != 0, 1);
      i_tx_not_empty <= 0;
      acc(1, 8'h6C, 32'h3);
      acc(1, 8'h6C, 32'h1);
      acc(0, 8'h6C, 32'h3);
      i_abandon_cause <= $random(seed);
      i_byte_done <= 1;
      @(posedge i_clock);
      i_byte_done <= 0;
      for (i = 0; i < 60 && o_busy !== 1'b0; i = i + 1)
         @(negedge i_clock);
      chk(o_busy, 0);
      acc(0, 8'h6C, 32'h1);
      acc(0, 8'h34, 32'h40);
      acc(1, 8'h30, 32'h40);
      @(negedge i_clock);
      chk(o_irq, 1);
      acc(0, 8'h2C, 32'h40);
      acc(0, 8'h80, {16'h0, i_abandon_cause});
      acc(0, 8'h54, 32'h1);
      acc(0, 8'h34, 32'h0);
      acc(0, 8'h80, 32'h0);
      @(negedge i_clock);
      chk(o_irq, 0);
      acc(1, 8'h6C, 32'h0);
      i_rx_active <= 1;
      @(negedge i_clock);
      chk(o_rx_flush, 1);
      chk(o_tx_flush, 1);
      chk(o_withhold_ack, 1);
      print_verdict;
   end
endmodule
